// >>> pacr_pkg.sv
// pacr_pkg: offsets, reset values, field positions and types shared by
// the calibration / detector / exact-frequency register bank.
// assumes a 5-bit register index and 24-bit register data.
`default_nettype none
package pacr_pkg;

  // register indices and data width
  localparam int unsigned       DATA_W        = 24;
  localparam logic [4:0]        IDX_VCO_CAL   = 5'h0A;
  localparam logic [4:0]        IDX_PD_PUMP   = 5'h0B;
  localparam logic [4:0]        IDX_EXACT     = 5'h0C;

  // values after reset
  localparam logic [23:0]       RST_VCO_CAL   = 24'h002046;
  localparam logic [23:0]       RST_PD_PUMP   = 24'h078061;
  localparam logic [23:0]       RST_EXACT     = 24'h000000;

  // calibration register fields
  localparam int unsigned       WIN_LSB       = 0;
  localparam int unsigned       CAL_OFF_BIT   = 11;
  localparam int unsigned       CDIV_LSB      = 13;
  localparam int unsigned       RELOCK_BIT    = 17;

  // detector register fields
  localparam int unsigned       POL_INV_BIT   = 4;
  localparam int unsigned       RAISE_EN_BIT  = 5;
  localparam int unsigned       LOWER_EN_BIT  = 6;
  localparam int unsigned       F_RAISE_BIT   = 9;
  localparam int unsigned       F_LOWER_BIT   = 10;
  localparam int unsigned       F_MID_BIT     = 11;

  // exact-frequency counts
  localparam logic [23:0]       EXACT_OFF     = 24'h000000;
  localparam logic [23:0]       EXACT_BAD     = 24'h000001;

  // measurement window lengths in reference-divider cycles, by code
  localparam logic [8:0]        WIN_LEN [8]   = '{9'h001, 9'h002, 9'h004,
                                                  9'h008, 9'h020, 9'h040,
                                                  9'h080, 9'h100};
  // calibration clock divide ratios minus one, by code
  localparam logic [4:0]        CDIV_TOP [4]  = '{5'h00, 5'h03, 5'h0F,
                                                  5'h1F};

  // measurement sequencer states
  typedef enum logic [0:0] {
    MS_IDLE = 1'b0,
    MS_MEAS = 1'b1
  } pacr_meas_t;

  // charge-pump drive to the analog side
  typedef struct packed {
    logic raise;
    logic lower;
    logic mid;
  } pacr_pump_t;

endpackage : pacr_pkg
`default_nettype wire

// >>> pacr_regs.sv
// pacr_regs: register bank and control logic for vco calibration setup,
// phase detector / charge pump steering and exact-frequency count.
// assumes reference and reference-divider events arrive as one-cycle
// enables synchronous to clk_sys_in, and a simple indexed register port.
`timescale 1ns/1ns
`default_nettype none
module pacr_regs
  import pacr_pkg::*;
(
  input  wire logic              clk_sys_in,       // 125 MHz system clock
  input  wire logic              rst_in,           // sync reset, active high
  input  wire logic [4:0]        reg_idx_in,       // register index
  input  wire logic [23:0]       reg_wdata_in,     // write data
  input  wire logic              reg_wr_in,        // write strobe
  input  wire logic              reg_rd_in,        // read strobe
  output logic      [23:0]       reg_rdata_out,    // read data, registered
  output logic                   reg_rvalid_out,   // read data valid pulse
  input  wire logic              xtal_tick_in,     // crystal reference event
  input  wire logic              rdiv_tick_in,     // reference divider event
  input  wire logic              cal_request_in,   // calibration wanted
  output logic                   cal_tick_out,     // divided fsm clock enable
  output logic                   cal_active_out,   // calibration permitted
  output logic                   meas_busy_out,    // measurement running
  output logic                   meas_done_out,    // measurement window ended
  input  wire logic              locked_in,        // lock detect state
  input  wire logic              lock_lost_in,     // lock detect failed pulse
  output logic                   relock_out,       // relock attempt pulse
  input  wire logic              pd_raise_in,      // raw detector raise
  input  wire logic              pd_lower_in,      // raw detector lower
  output pacr_pump_t             pump_out,         // charge-pump drive
  input  wire logic              mod_third_in,     // third-order modulator
  output logic      [23:0]       channel_count_out,// correction channel count
  output logic                   exact_active_out, // correction in effect
  output logic                   exact_invalid_out // count of one loaded
);

  // register storage
  logic [23:0]       cal_cfg_r,    cal_cfg_nxt;     // calibration config
  logic [23:0]       pd_ctl_r,     pd_ctl_nxt;      // detector control
  logic [23:0]       exact_r,      exact_nxt;       // channel count
  logic [23:0]       rdata_r,      rdata_nxt;       // read data
  logic              rvalid_r,     rvalid_nxt;      // read valid

  // register port: writes land at the next edge, reads answer one cycle on
  always_comb
  begin
    cal_cfg_nxt = cal_cfg_r;
    pd_ctl_nxt  = pd_ctl_r;
    exact_nxt   = exact_r;
    rdata_nxt   = rdata_r;
    rvalid_nxt  = reg_rd_in;
    if (reg_wr_in)
    begin
      unique case (reg_idx_in)
        IDX_VCO_CAL: cal_cfg_nxt = reg_wdata_in;
        // bits 8:7 stored as written; zero there is software's job
        IDX_PD_PUMP: pd_ctl_nxt  = reg_wdata_in;
        IDX_EXACT:   exact_nxt   = reg_wdata_in;
        default:     ;                           // unmapped write dropped
      endcase
    end
    if (reg_rd_in)
    begin
      unique case (reg_idx_in)
        IDX_VCO_CAL: rdata_nxt = cal_cfg_r;
        IDX_PD_PUMP: rdata_nxt = pd_ctl_r;
        IDX_EXACT:   rdata_nxt = exact_r;
        default:     rdata_nxt = 24'h000000;     // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cal_cfg_r <= RST_VCO_CAL;
      pd_ctl_r  <= RST_PD_PUMP;
      exact_r   <= RST_EXACT;
      rdata_r   <= 24'h000000;
      rvalid_r  <= 1'b0;
    end
    else
    begin
      cal_cfg_r <= cal_cfg_nxt;
      pd_ctl_r  <= pd_ctl_nxt;
      exact_r   <= exact_nxt;
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
    end
  end

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;

  // field views
  logic [2:0]        win_code;                       // window code
  logic [1:0]        cdiv_code;                      // clock divider code
  logic              cal_off;                        // calibration suppressed
  logic              relock_en;                      // single relock allowed
  assign win_code  = cal_cfg_r[WIN_LSB +: 3];
  assign cdiv_code = cal_cfg_r[CDIV_LSB +: 2];
  assign cal_off   = cal_cfg_r[CAL_OFF_BIT];
  assign relock_en = cal_cfg_r[RELOCK_BIT];

  // calibration clock divider; software keeps result under 50 MHz
  logic [4:0]        cdiv_cnt_r,   cdiv_cnt_nxt;    // crystal event count
  logic              ctick_r,      ctick_nxt;       // divided enable
  always_comb
  begin
    cdiv_cnt_nxt = cdiv_cnt_r;
    ctick_nxt    = 1'b0;
    if (xtal_tick_in)
    begin
      // a ratio change mid-count just finishes at the new top
      if (cdiv_cnt_r >= CDIV_TOP[cdiv_code])
      begin
        cdiv_cnt_nxt = 5'h00;
        ctick_nxt    = 1'b1;
      end
      else
        cdiv_cnt_nxt = cdiv_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      cdiv_cnt_r <= 5'h00;
      ctick_r    <= 1'b0;
    end
    else
    begin
      cdiv_cnt_r <= cdiv_cnt_nxt;
      ctick_r    <= ctick_nxt;
    end
  end

  assign cal_tick_out   = ctick_r;
  assign cal_active_out = ~cal_off;

  // measurement window sequencer; window must exceed 4 us
  pacr_meas_t        meas_st_r,    meas_st_nxt;     // sequencer state
  logic [8:0]        meas_cnt_r,   meas_cnt_nxt;    // cycles remaining
  logic              mdone_r,      mdone_nxt;       // window ended
  always_comb
  begin
    meas_st_nxt  = meas_st_r;
    meas_cnt_nxt = meas_cnt_r;
    mdone_nxt    = 1'b0;
    unique case (meas_st_r)
      MS_IDLE:
      begin
        // a disabled calibration never opens a window
        if (cal_request_in && !cal_off)
        begin
          meas_st_nxt  = MS_MEAS;
          meas_cnt_nxt = WIN_LEN[win_code];
        end
      end
      MS_MEAS:
      begin
        if (cal_off)
          meas_st_nxt = MS_IDLE;
        else if (rdiv_tick_in)
        begin
          if (meas_cnt_r == 9'h001)
          begin
            meas_st_nxt = MS_IDLE;
            mdone_nxt   = 1'b1;
          end
          else
            meas_cnt_nxt = meas_cnt_r - 9'h001;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      meas_st_r  <= MS_IDLE;
      meas_cnt_r <= 9'h000;
      mdone_r    <= 1'b0;
    end
    else
    begin
      meas_st_r  <= meas_st_nxt;
      meas_cnt_r <= meas_cnt_nxt;
      mdone_r    <= mdone_nxt;
    end
  end

  assign meas_busy_out = (meas_st_r == MS_MEAS);
  assign meas_done_out = mdone_r;

  // single relock: armed once lock is held, spent by the first failure
  logic              armed_r,      armed_nxt;       // attempt still available
  logic              relock_r,     relock_nxt;      // attempt pulse
  always_comb
  begin
    armed_nxt  = armed_r;
    relock_nxt = 1'b0;
    if (lock_lost_in)
    begin
      if (relock_en && armed_r)
        relock_nxt = 1'b1;
      armed_nxt = 1'b0;
    end
    else if (locked_in)
      armed_nxt = 1'b1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      armed_r  <= 1'b0;
      relock_r <= 1'b0;
    end
    else
    begin
      armed_r  <= armed_nxt;
      relock_r <= relock_nxt;
    end
  end

  assign relock_out = relock_r;

  // charge-pump steering; forces override detector, one cycle of latency
  pacr_pump_t        pump_r,       pump_nxt;        // registered drive
  logic              up_src;                         // polarity-corrected up
  logic              dn_src;                         // polarity-corrected dn
  logic              f_up;                           // raise force
  logic              f_dn;                           // lower force
  always_comb
  begin
    up_src = pd_ctl_r[POL_INV_BIT] ? pd_lower_in : pd_raise_in;
    dn_src = pd_ctl_r[POL_INV_BIT] ? pd_raise_in : pd_lower_in;
    f_up   = pd_ctl_r[F_RAISE_BIT];
    f_dn   = pd_ctl_r[F_LOWER_BIT];
    pump_nxt.raise = up_src & pd_ctl_r[RAISE_EN_BIT];
    pump_nxt.lower = dn_src & pd_ctl_r[LOWER_EN_BIT];
    pump_nxt.mid   = 1'b0;
    if (f_up && !f_dn)
    begin
      pump_nxt.raise = 1'b1;
      pump_nxt.lower = 1'b0;
    end
    else if (f_dn && !f_up)
    begin
      pump_nxt.raise = 1'b0;
      pump_nxt.lower = 1'b1;
    end
    else if (pd_ctl_r[F_MID_BIT])
    begin
      // both forces set cancel, so midpoint keeps control
      pump_nxt.raise = 1'b0;
      pump_nxt.lower = 1'b0;
      pump_nxt.mid   = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      pump_r <= '0;
    else
      pump_r <= pump_nxt;
  end

  assign pump_out = pump_r;

  // exact frequency: count value is software's quotient
  logic              ex_act_r,     ex_act_nxt;      // correction running
  logic              ex_bad_r,     ex_bad_nxt;      // invalid count held
  always_comb
  begin
    ex_bad_nxt = (exact_r == EXACT_BAD);
    ex_act_nxt = mod_third_in && (exact_r != EXACT_OFF) &&
                 (exact_r != EXACT_BAD);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      ex_act_r <= 1'b0;
      ex_bad_r <= 1'b0;
    end
    else
    begin
      ex_act_r <= ex_act_nxt;
      ex_bad_r <= ex_bad_nxt;
    end
  end

  assign channel_count_out = exact_r;
  assign exact_active_out  = ex_act_r;
  assign exact_invalid_out = ex_bad_r;

endmodule : pacr_regs
`default_nettype wire

// >>> pacr_regs_props.sv
// pacr_regs_props: port assertions for the register bank.
// assumes one clock and the synchronous reset of pacr_regs.
`timescale 1ns/1ns
`default_nettype none
module pacr_regs_props
  import pacr_pkg::*;
(
  input wire logic        clk_sys_in,        // system clock
  input wire logic        rst_in,            // sync reset
  input wire logic [4:0]  reg_idx_in,        // index
  input wire logic [23:0] reg_wdata_in,      // write data
  input wire logic        reg_wr_in,         // write strobe
  input wire logic        cal_active_out,    // cal permitted
  input wire logic        meas_busy_out,     // window running
  input wire logic        meas_done_out,     // window ended
  input wire logic        lock_lost_in,      // lock failed
  input wire logic        relock_out,        // relock pulse
  input wire pacr_pump_t  pump_out,          // pump drive
  input wire logic        mod_third_in,      // modulator type
  input wire logic [23:0] channel_count_out, // channel count
  input wire logic        exact_active_out,  // correction on
  input wire logic        exact_invalid_out  // count of one
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // write cycles; pump follows two edges later, flags likewise
  sequence s_cal_wr; reg_wr_in && reg_idx_in == IDX_VCO_CAL; endsequence
  sequence s_pd_wr; reg_wr_in && reg_idx_in == IDX_PD_PUMP; endsequence
  sequence s_ex_wr; reg_wr_in && reg_idx_in == IDX_EXACT; endsequence
  a_cal_off_follow: assert property (s_cal_wr |=>
    cal_active_out == !$past(reg_wdata_in[CAL_OFF_BIT]))
    else $error("cal active not following write");
  a_raise_force: assert property (s_pd_wr ##0
    reg_wdata_in[10:9] == 2'b01 |=> ##1 pump_out == 3'b100)
    else $error("raise force not applied");
  a_lower_force: assert property (s_pd_wr ##0
    reg_wdata_in[10:9] == 2'b10 |=> ##1 pump_out == 3'b010)
    else $error("lower force not applied");
  a_mid_force: assert property (s_pd_wr ##0 reg_wdata_in[11] &&
    reg_wdata_in[9] == reg_wdata_in[10] |=> ##1 pump_out == 3'b001)
    else $error("mid force wrong");
  a_count_flags: assert property (s_ex_wr |=>
    channel_count_out == $past(reg_wdata_in) ##1
    exact_invalid_out == ($past(reg_wdata_in, 2) == EXACT_BAD))
    else $error("channel count or invalid flag wrong");
  a_exact_mod: assert property (exact_active_out |->
    $past(mod_third_in)) else $error("correction without modulator");
  a_relock_once: assert property (relock_out |->
    $past(lock_lost_in) ##1 !relock_out) else $error("relock pulse wrong");
  a_meas_end: assert property (meas_done_out |->
    !meas_busy_out && $past(meas_busy_out)) else $error("done wrong");
endmodule : pacr_regs_props
bind pacr_regs pacr_regs_props i_pacr_regs_props (.clk_sys_in, .rst_in,
  .reg_idx_in, .reg_wdata_in, .reg_wr_in, .cal_active_out, .meas_busy_out,
  .meas_done_out, .lock_lost_in, .relock_out, .pump_out, .mod_third_in,
  .channel_count_out, .exact_active_out, .exact_invalid_out);
`default_nettype wire

// >>> pacr_regs_test.sv
// pacr_regs_test: self-checking bench for the register bank.
// assumes the checker is bound in beside the design.
`timescale 1ns/1ns
`default_nettype none
module pacr_regs_test
  import pacr_pkg::*;
;
  logic        clk_sys_in, rst_in, reg_wr_in, reg_rd_in;   // clock, port
  logic        xtal_tick_in, rdiv_tick_in, cal_request_in; // events
  logic        locked_in, lock_lost_in, pd_raise_in;       // lock, detector
  logic        pd_lower_in, mod_third_in;                  // detector, mod
  logic [4:0]  reg_idx_in;                                 // index
  logic [23:0] reg_wdata_in, reg_rdata_out, channel_count_out; // data
  logic        reg_rvalid_out, cal_tick_out, cal_active_out;   // status
  logic        meas_busy_out, meas_done_out, relock_out;       // status
  logic        exact_active_out, exact_invalid_out;            // flags
  pacr_pump_t  pump_out;                                   // pump drive
  int          error_cnt, checks, n, m;                    // counters
  int          done_n = 0;                                 // window ends seen
  logic [31:0] seed = 32'h4A0BB7A6;                        // fixed seed
  logic [31:0] r;                                          // random draw
  logic [23:0] d;                                          // write value
  int          div_n[4] = '{1, 4, 16, 32};                 // divide ratios
  int          win_n[8] = '{1, 2, 4, 8, 32, 64, 128, 256}; // windows
  pacr_regs i_pacr_regs (.clk_sys_in, .rst_in, .reg_idx_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .xtal_tick_in,
    .rdiv_tick_in, .cal_request_in, .cal_tick_out, .cal_active_out,
    .meas_busy_out, .meas_done_out, .locked_in, .lock_lost_in, .relock_out,
    .pd_raise_in, .pd_lower_in, .pump_out, .mod_third_in,
    .channel_count_out, .exact_active_out, .exact_invalid_out);
  // xorshift draws, repeatable from the seed
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected pump drive; forces win over the detector
  function automatic logic [2:0] pump_exp(input logic [23:0] v,
                                          input logic up, input logic dn);
    if (v[F_RAISE_BIT] != v[F_LOWER_BIT])
      return {v[F_RAISE_BIT], v[F_LOWER_BIT], 1'b0};
    if (v[F_MID_BIT])
      return 3'b001;
    return {(v[POL_INV_BIT] ? dn : up) & v[RAISE_EN_BIT],
            (v[POL_INV_BIT] ? up : dn) & v[LOWER_EN_BIT], 1'b0};
  endfunction : pump_exp
  task automatic chk(input string what, input logic [23:0] e, g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] idx, input logic [23:0] v);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_idx_in   <= idx;
    reg_wdata_in <= v;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // read; data and valid land one edge after the strobe
  task automatic rd(input logic [4:0] idx, input logic [23:0] e);
    @(posedge clk_sys_in);
    reg_rd_in  <= 1'b1;
    reg_idx_in <= idx;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("reg_rvalid_out", 24'h000001, 24'(reg_rvalid_out));
    chk("reg_rdata_out", e, reg_rdata_out);
  endtask : rd
  // sample a pulse or level over a number of cycles, counting highs
  task automatic count(input int len, ref logic s, output int k);
    k = 0;
    repeat (len)
    begin
      @(posedge clk_sys_in);
      #1;
      k += int'(s === 1'b1);
    end
  endtask : count
  task automatic final_report;
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // window ends counted over the whole run; a pulse lasts one cycle
  always @(posedge clk_sys_in)
    done_n <= done_n + int'(meas_done_out === 1'b1);
  // watchdog, well past the few thousand cycles needed
  initial
  begin
    #400000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    {rst_in, reg_wr_in, reg_rd_in, xtal_tick_in, rdiv_tick_in} = 5'h10;
    {cal_request_in, locked_in, lock_lost_in, pd_raise_in} = 4'h0;
    {pd_lower_in, mod_third_in, reg_idx_in, reg_wdata_in} = '0;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd(IDX_VCO_CAL, RST_VCO_CAL);
    rd(IDX_PD_PUMP, RST_PD_PUMP);
    rd(IDX_EXACT, RST_EXACT);
    rd(5'h00, 24'h000000);
    // random readback, reserved detector bits kept at zero
    // third-order modulator on while counts may be nonzero
    mod_third_in <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      r = rnd();
      d = r[23:0] & ((i % 3 == 1) ? 24'hFFFE7F : 24'hFFFFFF);
      wr(IDX_VCO_CAL + 5'(i % 3), d);
      rd(IDX_VCO_CAL + 5'(i % 3), d);
    end
    // every force, enable and polarity combination
    for (int k = 0; k < 64; k++)
    begin
      r = rnd();
      pd_raise_in <= r[0];
      pd_lower_in <= r[1];
      d = {12'h078, k[5:3], 2'b00, k[2:0], 4'h1};
      wr(IDX_PD_PUMP, d);
      @(posedge clk_sys_in);
      #1;
      chk("pump_out", 24'(pump_exp(d, r[0], r[1])), 24'(pump_out));
    end
    // divider: ticks every cycle, pulses counted over 64
    xtal_tick_in <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_VCO_CAL, {9'h000, c[1:0], 13'h0006});
      repeat (40) @(posedge clk_sys_in);
      count(64, cal_tick_out, n);
      chk("cal_tick_out", 24'(64 / div_n[c]), 24'(n));
    end
    // window lengths, then calibration switched off
    rdiv_tick_in <= 1'b1;
    for (int c = 0; c < 9; c++)
    begin
      // ticks stand for divider cycles; divider ratio taken as one
      d = (c == 8) ? 24'h002806 : {21'h000408, c[2:0]};
      wr(IDX_VCO_CAL, d);
      cal_request_in <= 1'b1;
      @(posedge clk_sys_in);
      cal_request_in <= 1'b0;
      // the start edge already shows busy, so sample it before counting
      #1;
      m = int'(meas_busy_out === 1'b1);
      count(300, meas_busy_out, n);
      chk("meas_busy_out", (c == 8) ? 24'h0 : 24'(win_n[c]),
          24'(n + m));
    end
    chk("cal_active_out", 24'h000000, 24'(cal_active_out));
    chk("meas_done_out", 24'h000008, 24'(done_n));
    // one relock try when enabled, none before lock is seen again
    for (int b = 0; b < 4; b++)
    begin
      if (b % 2 == 0)
        wr(IDX_VCO_CAL, b[1] ? 24'h022046 : 24'h002046);
      locked_in    <= (b % 2 == 0);
      repeat (3) @(posedge clk_sys_in);
      locked_in    <= 1'b0;
      lock_lost_in <= 1'b1;
      @(posedge clk_sys_in);
      lock_lost_in <= 1'b0;
      // the pulse stands in the cycle right after the failing edge
      #1;
      m = int'(relock_out === 1'b1);
      count(4, relock_out, n);
      chk("relock_out", 24'(b == 2), 24'(n + m));
    end
    // exact count boundaries and random values, modulator toggled
    for (int k = 0; k < 8; k++)
    begin
      r = rnd();
      d = (k < 4) ? ((k == 3) ? 24'hFFFFFF : 24'(k)) : r[23:0];
      // other modulator types only while the count stands at zero
      if (d != EXACT_OFF)
        mod_third_in <= 1'b1;
      wr(IDX_EXACT, d);
      mod_third_in <= r[31] | (d != EXACT_OFF);
      @(posedge clk_sys_in);
      #1;
      chk("channel_count_out", d, channel_count_out);
      chk("exact_invalid_out", 24'(d == 1), 24'(exact_invalid_out));
      chk("exact_active_out", 24'(d > 1), 24'(exact_active_out));
    end
    final_report();
  end
endmodule : pacr_regs_test
`default_nettype wire
